// *** bench/vms_mode_selector_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module vms_mode_selector_tb;
   logic clk;
   logic reset_n = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic irq;
   logic step_evt;
   logic ustep_at_45;
   logic [7:0] table_now_current;
   logic [7:0] table_45_current;
   logic load_stall_in = 1'b0;
   logic speed_stall_in = 1'b0;
   vms_pkg::vms_chop_t chop;
   logic [4:0] drive_current;
   logic powered_down;
   logic [7:0] target_current;
   logic stall_out;
   logic run = 1'b0;
   logic [7:0] gap = 8'h1E;
   int errors = 0;
   int tests_run = 0;
   int n;
   int t_irq;
   logic [31:0] rnd = 32'h68DC;
   logic [31:0] q;
   logic [31:0] ctl;
   logic prv;
   bit fst [3] = '{0, 0, 0};
   logic [7:0] rw_a [6] = '{8'h04, 8'h0C, 8'h10, 8'h14, 8'h20, 8'h24};
   logic [31:0] rw_m [6] = '{32'hFF, 32'hFFFFF, 32'hFFFFF, 32'hFFFFF, 32'hF, 32'h1FFF};
   // PWM limit above the reduction limit keeps the PWM velocity below it
   logic [31:0] cfg [6] = '{32'h3, 32'h28, 32'h1E, 32'h14, 32'h1, 32'h51A};
   logic [7:0] gaps [7] = '{8'h32, 8'h23, 8'h19, 8'h0F, 8'h15, 8'h16, 8'h17};

   vms_mode_selector #(.STST_CYCLES(64), .PD_STEP_CYCLES(16)) vms_mode_selector_inst (
      .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq(irq), .step_evt(step_evt),
      .ustep_at_45(ustep_at_45), .table_now_current(table_now_current),
      .table_45_current(table_45_current), .load_stall_in(load_stall_in),
      .speed_stall_in(speed_stall_in), .chop(chop), .drive_current(drive_current),
      .powered_down(powered_down), .target_current(target_current), .stall_out(stall_out)
   );

   vms_step_source vms_step_source_inst (
      .clk(clk), .reset_n(reset_n), .run(run), .gap(gap), .step_evt(step_evt),
      .ustep_at_45(ustep_at_45), .table_now_current(table_now_current),
      .table_45_current(table_45_current)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic guard(input bit hit);
      if (hit) begin
         $display("unexpected at %0t: wait ran out", $time);
         errors++;
         stop_test();
      end
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask

   // Request held until waitrequest is sampled low; data taken at that edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      avs_address <= a;
      avs_read <= ~wr;
      avs_write <= wr;
      avs_writedata <= d;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 40);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      guard(k >= 40);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
      bus(1'b0, a, 32'h0);
      chk(q, e, what);
   endtask

   task automatic step_sync;
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (step_evt !== 1'b1 && k < 200);
      guard(k >= 200);
   endtask

   // Region flags with hysteresis: enter at or below the limit, leave on the scaled value
   task automatic model(input int iv);
      for (int i = 0; i < 3; i++) begin
         if (iv <= int'(cfg[i + 1])) begin
            fst[i] = 1'b1;
         end else if (iv - (iv >> (ctl[1] ? 5 : 4)) - 1 > int'(cfg[i + 1])) begin
            fst[i] = 1'b0;
         end
      end
   endtask

   task automatic chk_outs(input int iv);
      vms_pkg::vms_chop_t e;
      logic hv;
      logic cl;
      logic [7:0] tc;
      logic st;
      hv = fst[2];
      cl = hv & ctl[3];
      e.fullstep = hv & ctl[2];
      e.pwm_en = ctl[0] & !fst[0] & !fst[1] & !hv;
      e.speed_ctl_en = fst[0] & e.fullstep;
      e.cr_en = ctl[4] & fst[1] & !hv;
      e.stall_stop_en = ctl[5] & fst[1];
      e.stall_out_en = ctl[5] & fst[1];
      e.classic = cl;
      e.sync = hv ? 4'h0 : ctl[11:8];
      e.fast_decay = cl ? 4'h0 : ctl[19:16];
      e.toff = cl ? {ctl[15:12], 1'b0} : {1'b0, ctl[15:12]};
      tc = e.fullstep ? table_45_current : table_now_current;
      chk(32'(chop), 32'(e), "chop");
      chk(32'(target_current), 32'(tc), "target");
      st = (e.fullstep ? speed_stall_in : load_stall_in) & e.stall_out_en;
      chk(32'(stall_out), 32'(st), "stall");
      chk(32'(drive_current), 32'h1A, "run current");
      rd(vms_pkg::A_INTERVAL, 32'(iv), "interval");
      rd(vms_pkg::A_STATUS, 32'({e.fullstep, hv, fst[1] & !hv, !fst[0], 2'b00}), "status");
      bus(1'b0, vms_pkg::A_IRQ_STAT, 32'h0);
      chk(q & 32'h4, 32'({hv & !prv, 2'b00}), "hv event");
      prv = hv;
   endtask

   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      for (int a = 0; a < 10; a++) begin
         // Saturated interval sits above a zero PWM limit, so the PWM region shows
         rd(8'(a * 4), (a == 2) ? 32'hFFFFF : ((a == 6) ? 32'h4 : 32'h0), "reset value");
      end
      bus(1'b1, 8'h30, 32'hFFFFFFFF);
      rd(8'h30, 32'h0, "unmapped");
      run <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         bus(1'b1, rw_a[i], rnd);
         rd(rw_a[i], rnd & rw_m[i], "read back");
         bus(1'b1, rw_a[i], cfg[i]);
      end
      // Motor is turning, so the voltage-PWM enable must not take
      ctl = 32'h000C793D;
      bus(1'b1, vms_pkg::A_CTRL, ctl);
      ctl[0] = 1'b0;
      rd(vms_pkg::A_CTRL, ctl, "pwm enable refused");
      model(30);
      repeat (3) step_sync();
      bus(1'b0, vms_pkg::A_IRQ_STAT, 32'h0);
      step_sync();
      run <= 1'b0;
      n = 0;
      t_irq = 0;
      while (powered_down !== 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
         if (irq === 1'b1 && t_irq == 0) t_irq = n;
      end
      chk(32'(t_irq inside {[65:68]}), 32'h1, "standstill time");
      chk(32'(n inside {[97:99]}), 32'h1, "power-down delay");
      repeat (2) @(posedge clk);
      chk(32'(drive_current), 32'h05, "hold current");
      model(1048575);
      bus(1'b1, vms_pkg::A_INTERVAL, 32'h0);
      rd(vms_pkg::A_INTERVAL, 32'hFFFFF, "saturated");
      rd(vms_pkg::A_STATUS, 32'h7, "standstill status");
      rd(vms_pkg::A_IRQ_STAT, 32'h3, "events");
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0, "irq after clear");
      ctl[0] = 1'b1;
      bus(1'b1, vms_pkg::A_CTRL, ctl);
      rd(vms_pkg::A_CTRL, ctl, "pwm enable at rest");
      bus(1'b1, vms_pkg::A_IRQ_MASK, 32'h4);
      prv = 1'b0;
      for (int h = 0; h < 2; h++) begin
         ctl[1] = h[0];
         bus(1'b1, vms_pkg::A_CTRL, ctl);
         run <= 1'b1;
         // Rising gaps after the fastest one walk through the hysteresis band
         for (int k = 0; k < 7; k++) begin
            rnd = lfsr(rnd);
            gap <= gaps[k];
            load_stall_in <= rnd[0];
            speed_stall_in <= rnd[1];
            repeat (4) step_sync();
            model(int'(gaps[k]));
            repeat (3) @(posedge clk);
            chk_outs(int'(gaps[k]));
         end
      end
      stop_test();
   end
endmodule // vms_mode_selector_tb
`default_nettype wire

// *** bench/vms_step_source.sv ***
`timescale 1ns/1ns
`default_nettype none
module vms_step_source #(
   parameter logic [7:0] T45_LEVEL = 8'hB5
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Pace set by the bench
   input wire logic run,
   input wire logic [7:0] gap,
   // Step link towards the selector
   output logic step_evt,
   output logic ustep_at_45,
   output logic [7:0] table_now_current,
   output logic [7:0] table_45_current
);
   logic [7:0] cnt_ff;
   logic [7:0] nxt_cnt;
   logic fire;

   // Pacing freezes while stopped, so restarting never adds a short interval
   assign fire = run && (cnt_ff >= gap - 8'h01);
   assign nxt_cnt = fire ? 8'h00 : (run ? cnt_ff + 8'h01 : cnt_ff);
   assign table_45_current = T45_LEVEL;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_ff <= 8'h00;
         step_evt <= 1'b0;
         ustep_at_45 <= 1'b0;
         table_now_current <= 8'h20;
      end else begin
         cnt_ff <= nxt_cnt;
         step_evt <= fire;
         ustep_at_45 <= ustep_at_45 ^ fire;
         // Live entry moves with each step so a stale target shows up
         table_now_current <= table_now_current + (fire ? 8'h13 : 8'h00);
      end
   end
endmodule // vms_step_source
`default_nettype wire

// *** rtl/vms_interval_meter.sv ***
`timescale 1ns/1ns
`default_nettype none
module vms_interval_meter #(
   parameter int unsigned STST_CYCLES = vms_pkg::STST_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Step events
   input wire logic step_evt,
   // Results
   output logic [19:0] interval,
   output logic stst
);
   localparam logic [19:0] STST_LAST = 20'(STST_CYCLES - 1);

   logic [19:0] cnt_ff;
   logic [19:0] interval_ff;
   logic stst_ff;

   wire cnt_full = (cnt_ff == vms_pkg::IV_MAX);
   wire stst_hit = (cnt_ff == STST_LAST);
   wire [19:0] nxt_cnt = step_evt ? 20'h00000 : (cnt_full ? cnt_ff : cnt_ff + 20'h00001);
   wire [19:0] step_len = cnt_full ? vms_pkg::IV_MAX : cnt_ff + 20'h00001;
   wire [19:0] nxt_interval = step_evt ? step_len : (stst_hit ? vms_pkg::IV_MAX : interval_ff);
   wire nxt_stst = step_evt ? 1'b0 : (stst_ff | stst_hit);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_ff <= 20'h00000;
         interval_ff <= vms_pkg::IV_MAX;
         stst_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         interval_ff <= nxt_interval;
         stst_ff <= nxt_stst;
      end
   end

   assign interval = interval_ff;
   assign stst = stst_ff;

   chk_interval_latch: assert property (@(posedge clk) disable iff (!reset_n)
      step_evt && !cnt_full |=> interval_ff == $past(cnt_ff) + 20'h00001)
      else $error("step interval not latched on step event");
   chk_stst_sat: assert property (@(posedge clk) disable iff (!reset_n)
      stst_ff |-> interval_ff == vms_pkg::IV_MAX)
      else $error("interval not saturated in standstill");
   chk_stst_time: assert property (@(posedge clk) disable iff (!reset_n)
      stst_hit && !step_evt |=> stst_ff)
      else $error("standstill not flagged after idle count");
endmodule // vms_interval_meter
`default_nettype wire

// *** rtl/vms_mode_selector.sv ***
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module vms_mode_selector #(
   parameter int unsigned STST_CYCLES = vms_pkg::STST_CYCLES,
   parameter int unsigned PD_STEP_CYCLES = vms_pkg::PD_STEP_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Avalon-MM slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Interrupt
   output logic irq,
   // Step source
   input wire logic step_evt,
   input wire logic ustep_at_45,
   input wire logic [7:0] table_now_current,
   input wire logic [7:0] table_45_current,
   // Stall detectors
   input wire logic load_stall_in,
   input wire logic speed_stall_in,
   // Chopper and power stage control
   output vms_pkg::vms_chop_t chop,
   output logic [4:0] drive_current,
   output logic powered_down,
   output logic [7:0] target_current,
   output logic stall_out
);
   localparam logic [19:0] PD_STEP_LAST = 20'(PD_STEP_CYCLES - 1);

   // Registers
   vms_pkg::vms_ctrl_t ctrl_ff;
   logic [7:0] pdown_ff;
   logic [19:0] lim_ff [3];
   logic [12:0] current_ff;
   logic [3:0] irq_stat_ff;
   logic [3:0] irq_mask_ff;
   logic [31:0] rdata_ff;
   logic wait_ff;
   logic irq_ff;

   // Mode state
   logic [2:0] fast_ff;
   logic fullstep_ff;
   logic down_ff;
   logic [19:0] pre_ff;
   logic [7:0] steps_ff;
   logic stst_d_ff;
   logic hv_d_ff;
   vms_pkg::vms_chop_t chop_ff;
   logic [4:0] drive_ff;
   logic [7:0] target_ff;
   logic stall_ff;

   logic [19:0] interval;
   logic stst;

   vms_interval_meter #(
      .STST_CYCLES(STST_CYCLES)
   ) u_meter (
      .clk(clk),
      .reset_n(reset_n),
      .step_evt(step_evt),
      .interval(interval),
      .stst(stst)
   );

   // Bus decode; an access completes on the cycle after it is seen
   wire access = avs_read | avs_write;
   wire done = access & ~wait_ff;
   wire wr = avs_write & ~wait_ff;
   wire rd_done = avs_read & ~wait_ff;
   wire wr_ctrl = wr && avs_address == vms_pkg::A_CTRL;
   wire wr_pdown = wr && avs_address == vms_pkg::A_PDOWN;
   wire wr_pwm = wr && avs_address == vms_pkg::A_PWM_LIM;
   wire wr_cr = wr && avs_address == vms_pkg::A_CR_LIM;
   wire wr_hv = wr && avs_address == vms_pkg::A_HV_LIM;
   wire wr_mask = wr && avs_address == vms_pkg::A_IRQ_MASK;
   wire wr_cur = wr && avs_address == vms_pkg::A_CURRENT;
   wire rd_irq = rd_done && avs_address == vms_pkg::A_IRQ_STAT;

   // Region decode
   wire pwm_zone = ~fast_ff[vms_pkg::T_PWM];
   wire cr_fast = fast_ff[vms_pkg::T_CR];
   wire hv_zone = fast_ff[vms_pkg::T_HV];
   wire cr_zone = cr_fast & ~hv_zone;
   wire fs_want = hv_zone & ctrl_ff.hv_fullstep;
   wire classic = hv_zone & ctrl_ff.hv_classic;

   wire [5:0] status = {fullstep_ff, hv_zone, cr_zone, pwm_zone, down_ff, stst};

   // Control write; PWM enable may only be switched on in standstill
   vms_pkg::vms_ctrl_t wdata_ctrl;
   assign wdata_ctrl = vms_pkg::vms_ctrl_t'(avs_writedata[19:0]);
   wire pwm_on_blocked = wdata_ctrl.en_pwm & ~ctrl_ff.en_pwm & ~stst;
   vms_pkg::vms_ctrl_t nxt_ctrl;
   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (wr_ctrl) begin
         nxt_ctrl = wdata_ctrl;
         nxt_ctrl.unused = 2'h0;
         if (pwm_on_blocked) begin
            nxt_ctrl.en_pwm = 1'b0;
         end
      end
   end

   // Read mux, unmapped addresses read zero
   logic [31:0] nxt_rdata;
   always_comb begin
      nxt_rdata = 32'h00000000;
      unique case (avs_address)
         vms_pkg::A_CTRL: nxt_rdata = {12'h000, ctrl_ff};
         vms_pkg::A_PDOWN: nxt_rdata = {24'h000000, pdown_ff};
         vms_pkg::A_INTERVAL: nxt_rdata = {12'h000, interval};
         vms_pkg::A_PWM_LIM: nxt_rdata = {12'h000, lim_ff[vms_pkg::T_PWM]};
         vms_pkg::A_CR_LIM: nxt_rdata = {12'h000, lim_ff[vms_pkg::T_CR]};
         vms_pkg::A_HV_LIM: nxt_rdata = {12'h000, lim_ff[vms_pkg::T_HV]};
         vms_pkg::A_STATUS: nxt_rdata = {26'h0000000, status};
         vms_pkg::A_IRQ_STAT: nxt_rdata = {28'h0000000, irq_stat_ff};
         vms_pkg::A_IRQ_MASK: nxt_rdata = {28'h0000000, irq_mask_ff};
         vms_pkg::A_CURRENT: nxt_rdata = {19'h00000, current_ff};
         default: nxt_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wait_ff <= 1'b1;
         rdata_ff <= 32'h00000000;
      end else begin
         wait_ff <= ~(access & wait_ff);
         rdata_ff <= (avs_read & wait_ff) ? nxt_rdata : rdata_ff;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_ff <= vms_pkg::vms_ctrl_t'(vms_pkg::CTRL_RST);
         pdown_ff <= vms_pkg::PDOWN_RST;
         current_ff <= vms_pkg::CURRENT_RST;
         irq_mask_ff <= vms_pkg::IRQ_RST;
      end else begin
         ctrl_ff <= nxt_ctrl;
         pdown_ff <= wr_pdown ? avs_writedata[7:0] : pdown_ff;
         current_ff <= wr_cur ? avs_writedata[12:0] : current_ff;
         irq_mask_ff <= wr_mask ? avs_writedata[3:0] : irq_mask_ff;
      end
   end

   // Threshold comparators with hysteresis, one per limit
   wire [19:0] iv_scaled = (interval == 20'h00000) ? 20'h00000 :
      interval - (ctrl_ff.small_hyst ? (interval >> 5) : (interval >> 4)) - 20'h00001;
   wire [2:0] lim_wr = {wr_hv, wr_cr, wr_pwm};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_thr
         wire nxt_fast = fast_ff[gi] ? (iv_scaled <= lim_ff[gi]) : (interval <= lim_ff[gi]);
         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               lim_ff[gi] <= vms_pkg::LIM_RST;
               fast_ff[gi] <= 1'b0;
            end else begin
               lim_ff[gi] <= lim_wr[gi] ? avs_writedata[19:0] : lim_ff[gi];
               fast_ff[gi] <= nxt_fast;
            end
         end
      end
   endgenerate

   // Power-down timer: delay 1 is one clock, each further step adds a prescaler period
   wire pd_zero = (pdown_ff == 8'h00);
   wire pd_last = (steps_ff == pdown_ff - 8'h01);
   wire pre_wrap = (pre_ff == PD_STEP_LAST);
   wire nxt_down = stst & (down_ff | pd_zero | pd_last);
   wire [19:0] nxt_pre = (stst & ~down_ff & ~pre_wrap) ? pre_ff + 20'h00001 : 20'h00000;
   wire [7:0] nxt_steps = ~stst ? 8'h00 : ((pre_wrap & ~down_ff) ? steps_ff + 8'h01 : steps_ff);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         down_ff <= 1'b0;
         pre_ff <= 20'h00000;
         steps_ff <= 8'h00;
      end else begin
         down_ff <= nxt_down;
         pre_ff <= nxt_pre;
         steps_ff <= nxt_steps;
      end
   end

   // Fullstep changes over only at the 45 degree position
   wire nxt_fullstep = ustep_at_45 ? fs_want : fullstep_ff;

   // Chopper control bundle
   vms_pkg::vms_chop_t nxt_chop;
   always_comb begin
      nxt_chop.pwm_en = ctrl_ff.en_pwm & pwm_zone & ~cr_zone & ~hv_zone;
      nxt_chop.speed_ctl_en = ~pwm_zone & fullstep_ff;
      nxt_chop.cr_en = ctrl_ff.cr_cfg & cr_zone;
      nxt_chop.stall_stop_en = ctrl_ff.stall_cfg & cr_fast;
      nxt_chop.stall_out_en = ctrl_ff.stall_cfg & cr_fast;
      nxt_chop.classic = classic;
      nxt_chop.fullstep = fullstep_ff;
      nxt_chop.sync = hv_zone ? 4'h0 : ctrl_ff.sync;
      nxt_chop.fast_decay = classic ? 4'h0 : ctrl_ff.fast_decay;
      nxt_chop.toff = classic ? {ctrl_ff.toff, 1'b0} : {1'b0, ctrl_ff.toff};
   end

   // Hold level applies once the power-down delay has run out
   wire [4:0] run_cur = current_ff[vms_pkg::RUN_LSB +: 5];
   wire [4:0] hold_cur = current_ff[vms_pkg::HOLD_LSB +: 5];
   wire [4:0] nxt_drive = (stst & down_ff) ? hold_cur : run_cur;
   wire [7:0] nxt_target = fullstep_ff ? table_45_current : table_now_current;
   wire stall_src = fullstep_ff ? speed_stall_in : load_stall_in;
   wire nxt_stall = stall_src & ctrl_ff.stall_cfg & cr_fast;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fullstep_ff <= 1'b0;
         chop_ff <= '0;
         drive_ff <= 5'h00;
         target_ff <= 8'h00;
         stall_ff <= 1'b0;
      end else begin
         fullstep_ff <= nxt_fullstep;
         chop_ff <= nxt_chop;
         drive_ff <= nxt_drive;
         target_ff <= nxt_target;
         stall_ff <= nxt_stall;
      end
   end

   // Sticky events; a set in the clearing read cycle survives
   wire [3:0] evt;
   assign evt[vms_pkg::IRQ_STST] = stst & ~stst_d_ff;
   assign evt[vms_pkg::IRQ_PDOWN] = nxt_down & ~down_ff;
   assign evt[vms_pkg::IRQ_HV] = hv_zone & ~hv_d_ff;
   assign evt[vms_pkg::IRQ_STALL] = nxt_stall & ~stall_ff;
   // Only bits already handed out in read data are cleared, so an event landing
   // between the data capture and the completing edge is not lost
   wire [3:0] nxt_irq_stat = (rd_irq ? irq_stat_ff & ~rdata_ff[3:0] : irq_stat_ff) | evt;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stst_d_ff <= 1'b0;
         hv_d_ff <= 1'b0;
         irq_stat_ff <= vms_pkg::IRQ_RST;
         irq_ff <= 1'b0;
      end else begin
         stst_d_ff <= stst;
         hv_d_ff <= hv_zone;
         irq_stat_ff <= nxt_irq_stat;
         irq_ff <= |(nxt_irq_stat & irq_mask_ff);
      end
   end

   assign avs_readdata = rdata_ff;
   assign avs_waitrequest = wait_ff;
   assign irq = irq_ff;
   assign chop = chop_ff;
   assign drive_current = drive_ff;
   assign powered_down = down_ff;
   assign target_current = target_ff;
   assign stall_out = stall_ff;

   chk_sync_forced: assert property (@(posedge clk) disable iff (!reset_n)
      hv_zone |=> chop_ff.sync == 4'h0)
      else $error("sync not forced off at high velocity");
   chk_classic_decay: assert property (@(posedge clk) disable iff (!reset_n)
      hv_zone && ctrl_ff.hv_classic |=> chop_ff.classic && chop_ff.fast_decay == 4'h0)
      else $error("classic chopper not selected at high velocity");
   chk_toff_double: assert property (@(posedge clk) disable iff (!reset_n)
      classic |=> chop_ff.toff == {$past(ctrl_ff.toff), 1'b0})
      else $error("off time not doubled");
   chk_pwm_off_hv: assert property (@(posedge clk) disable iff (!reset_n)
      hv_zone |=> !chop_ff.pwm_en && !chop_ff.cr_en)
      else $error("pwm or reduction active at high velocity");
   chk_cr_zone: assert property (@(posedge clk) disable iff (!reset_n)
      cr_zone && ctrl_ff.cr_cfg |=> chop_ff.cr_en && !chop_ff.pwm_en)
      else $error("reduction region handled wrongly");
   chk_stall_zone: assert property (@(posedge clk) disable iff (!reset_n)
      !cr_fast |=> !chop_ff.stall_stop_en && !stall_ff)
      else $error("stall enabled above reduction interval");
   chk_pwm_zone: assert property (@(posedge clk) disable iff (!reset_n)
      pwm_zone |=> !chop_ff.speed_ctl_en)
      else $error("speed control active in pwm region");
   chk_fullstep_45: assert property (@(posedge clk) disable iff (!reset_n)
      $changed(fullstep_ff) |-> $past(ustep_at_45))
      else $error("fullstep switched away from 45 degrees");
   chk_current_sel: assert property (@(posedge clk) disable iff (!reset_n)
      !stst |=> drive_ff == $past(run_cur))
      else $error("run current not selected while moving");
   chk_pd_zero: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(stst) && pd_zero ##1 stst |-> down_ff)
      else $error("zero delay power-down late");
   chk_pwm_guard: assert property (@(posedge clk) disable iff (!reset_n)
      !ctrl_ff.en_pwm && !stst |=> !ctrl_ff.en_pwm)
      else $error("pwm enabled while moving");
   chk_pwm_enable: assert property (@(posedge clk) disable iff (!reset_n)
      pwm_zone && !cr_fast && !hv_zone && ctrl_ff.en_pwm |=> chop_ff.pwm_en)
      else $error("pwm chopper not enabled in pwm region");
   chk_down_stst: assert property (@(posedge clk) disable iff (!reset_n)
      !stst |=> !down_ff)
      else $error("powered down while moving");
   chk_hold_level: assert property (@(posedge clk) disable iff (!reset_n)
      stst && down_ff |=> drive_ff == $past(hold_cur))
      else $error("hold current not selected after power-down");
   chk_fullstep_entry: assert property (@(posedge clk) disable iff (!reset_n)
      fs_want && ustep_at_45 |=> fullstep_ff)
      else $error("fullstep not entered at 45 degrees");
   chk_target_fs: assert property (@(posedge clk) disable iff (!reset_n)
      fullstep_ff |=> target_ff == $past(table_45_current))
      else $error("fullstep target not taken from 45 degree entry");
   chk_stall_source: assert property (@(posedge clk) disable iff (!reset_n)
      fullstep_ff && ctrl_ff.stall_cfg && cr_fast |=> stall_ff == $past(speed_stall_in))
      else $error("stall source not switched in fullstep");
endmodule // vms_mode_selector
`default_nettype wire

// *** rtl/vms_pkg.sv ***
package vms_pkg;

   // Bus map (byte addresses, one 32-bit word each)
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_PDOWN = 8'h04;
   localparam logic [7:0] A_INTERVAL = 8'h08;
   localparam logic [7:0] A_PWM_LIM = 8'h0C;
   localparam logic [7:0] A_CR_LIM = 8'h10;
   localparam logic [7:0] A_HV_LIM = 8'h14;
   localparam logic [7:0] A_STATUS = 8'h18;
   localparam logic [7:0] A_IRQ_STAT = 8'h1C;
   localparam logic [7:0] A_IRQ_MASK = 8'h20;
   localparam logic [7:0] A_CURRENT = 8'h24;

   localparam int IV_W = 20;
   localparam logic [19:0] IV_MAX = 20'hFFFFF;
   localparam int unsigned STST_CYCLES = 1048576;
   localparam int unsigned PD_STEP_CYCLES = 262144;

   // Reset values
   localparam logic [19:0] CTRL_RST = 20'h00000;
   localparam logic [7:0] PDOWN_RST = 8'h00;
   localparam logic [19:0] LIM_RST = 20'h00000;
   localparam logic [12:0] CURRENT_RST = 13'h0000;
   localparam logic [3:0] IRQ_RST = 4'h0;

   // Current register fields
   localparam int RUN_LSB = 0;
   localparam int HOLD_LSB = 8;

   // Interrupt status bits
   localparam int IRQ_STST = 0;
   localparam int IRQ_PDOWN = 1;
   localparam int IRQ_HV = 2;
   localparam int IRQ_STALL = 3;

   // Threshold index in the comparator array
   localparam int T_PWM = 0;
   localparam int T_CR = 1;
   localparam int T_HV = 2;

   typedef struct packed {
      logic [3:0] fast_decay;
      logic [3:0] toff;
      logic [3:0] sync;
      logic [1:0] unused;
      logic stall_cfg;
      logic cr_cfg;
      logic hv_classic;
      logic hv_fullstep;
      logic small_hyst;
      logic en_pwm;
   } vms_ctrl_t;

   typedef struct packed {
      logic pwm_en;
      logic speed_ctl_en;
      logic cr_en;
      logic stall_stop_en;
      logic stall_out_en;
      logic classic;
      logic fullstep;
      logic [3:0] sync;
      logic [3:0] fast_decay;
      logic [4:0] toff;
   } vms_chop_t;

endpackage
